// *** design/or_move_pkg.sv ***
// constants and types for the or/move/pointer-load execution datapath
package or_move_pkg;

	// ****************************************
	// instruction encodings
	// ****************************************
	localparam logic [7:0]  OR_LITERAL_BYTE    = 8'h09;            // 0000 1001 kkkk kkkk
	localparam logic [5:0]  OR_FILE_OPCODE     = 6'h04;            // 0001 00da ffff ffff
	localparam logic [5:0]  MOVE_FILE_OPCODE   = 6'h14;            // 0101 00da ffff ffff
	localparam logic [9:0]  POINTER_FIRST_CODE = 10'h3B8;          // 1110 1110 00ff kkkk
	localparam logic [7:0]  POINTER_SECOND_HI  = 8'hF0;            // 1111 0000 kkkk kkkk
	localparam int          DEST_BIT           = 9;
	localparam int          BANK_BIT           = 8;
	localparam logic [7:0]  INDEXED_LIMIT      = 8'h5F;            // 95
	localparam logic [3:0]  ACCESS_HIGH_BANK   = 4'hF;
	localparam logic [1:0]  INDEX_POINTER      = 2'h2;
	localparam logic [1:0]  POINTER_MAX        = 2'h2;

	// ****************************************
	// status flag positions
	// ****************************************
	localparam int          ZERO_BIT           = 2;
	localparam int          NEG_BIT            = 4;

	// ****************************************
	// register map, byte addresses
	// ****************************************
	localparam logic [7:0]  CONTROL_OFFSET     = 8'h00;
	localparam logic [7:0]  ACC_OFFSET         = 8'h04;
	localparam logic [7:0]  BANK_OFFSET        = 8'h08;
	localparam logic [7:0]  STATUS_OFFSET      = 8'h0C;
	localparam logic [7:0]  POINTER0_OFFSET    = 8'h10;
	localparam logic [7:0]  POINTER1_OFFSET    = 8'h14;
	localparam logic [7:0]  POINTER2_OFFSET    = 8'h18;
	localparam logic [7:0]  MEM_ADDR_OFFSET    = 8'h1C;
	localparam logic [7:0]  MEM_DATA_OFFSET    = 8'h20;
	localparam logic [7:0]  EXEC_INFO_OFFSET   = 8'h24;
	localparam logic [1:0]  RESP_OKAY          = 2'h0;
	localparam logic [1:0]  RESP_SLVERR        = 2'h2;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0]  ACC_RESET          = 8'h00;
	localparam logic [3:0]  BANK_RESET         = 4'h0;
	localparam logic [4:0]  STATUS_RESET       = 5'h00;
	localparam logic [11:0] POINTER_RESET      = 12'h000;

	// ****************************************
	// memory size
	// ****************************************
	localparam int          MEM_ADDR_W         = 12;
	localparam int          MEM_DEPTH          = 4096;

	typedef enum logic [2:0] {
		PH_IDLE   = 3'b000,
		PH_Q1     = 3'b001,
		PH_Q2     = 3'b010,
		PH_Q3     = 3'b011,
		PH_Q4     = 3'b100,
		PH_BUS_RD = 3'b101
	} phase_t;

	typedef enum logic [2:0] {
		OP_NONE      = 3'b000,
		OP_OR_LIT    = 3'b001,
		OP_OR_FILE   = 3'b010,
		OP_MOVE_FILE = 3'b011,
		OP_PTR_HI    = 3'b100,
		OP_PTR_LO    = 3'b101
	} op_t;

endpackage : or_move_pkg

// *** design/file_memory.sv ***
// data memory of the core: one port, registered read data
`timescale 1ns/100ps
module file_memory
	import or_move_pkg::*;
(
	// clock and reset
	input  wire logic                  clock,
	input  wire logic                  rst_b,
	// access port
	input  wire logic [MEM_ADDR_W-1:0] addr,
	input  wire logic                  we,
	input  wire logic [7:0]            wdata,
	output logic      [7:0]            rdata
);

	logic [7:0] mem [MEM_DEPTH];

	// ****************************************
	// write port
	// ****************************************
	always_ff @(posedge clock) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	// ****************************************
	// registered read, old data on a write
	// ****************************************
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= 8'h00;
		end else begin
			rdata <= mem[addr];
		end
	end

endmodule : file_memory

// *** design/or_move_pointer_load_exec.sv ***
// execution datapath for or-literal, or-file, move-file and pointer-load
//
// Behaviour
// - or-literal: accumulator ORed with eight-bit literal, result back into accumulator
// - or-literal recognised by upper byte 0000 1001, low byte is literal
// - or-file: accumulator ORed with file register; opcode, d, a, eight address bits
// - d zero writes accumulator, d one writes file register back
// - a zero selects access bank, a one takes bank from bank selector
// - extended set, a zero, address at or below 5Fh: indexed literal offset
// - these three instructions change only negative and zero flags
// - move-file copies file register to destination, encoding 0101 00da
// - eight-bit address is an offset within a 256-byte bank
// - pointer-load writes 12-bit literal into chosen pointer, flags untouched
// - pointer field picks one of three pointers, index zero to two
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module or_move_pointer_load_exec
	import or_move_pkg::*;
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst_b,
	// instruction from decoder
	input  wire logic        instr_valid,
	input  wire logic [15:0] instr_word,
	output logic             instr_ready,
	// axi4-lite write channels
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// axi4-lite read channels
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready
);

	typedef struct packed {
		phase_t          phase;
		op_t             op;
		logic [15:0]     word;
		logic [11:0]     ea;
		logic [7:0]      res;
		logic [7:0]      acc;
		logic [3:0]      bank;
		logic [4:0]      status;
		logic [2:0][11:0] ptr;
		logic [1:0]      ptr_sel;
		logic            lo_pending;
		logic            ext_en;
		logic [11:0]     mem_addr;
		logic            instr_ready;
		logic            aw_got;
		logic            w_got;
		logic [7:0]      awaddr;
		logic [31:0]     wdata;
		logic [3:0]      wstrb;
		logic            awready;
		logic            wready;
		logic            bvalid;
		logic [1:0]      bresp;
		logic            ar_got;
		logic [7:0]      araddr;
		logic            arready;
		logic            rvalid;
		logic [1:0]      rresp;
		logic [31:0]     rdata;
	} state_t;

	state_t      s_q;
	state_t      s_d;
	logic [11:0] ram_addr;
	logic        ram_we;
	logic [7:0]  ram_wdata;
	logic [7:0]  ram_rdata;
	logic        take_instr;
	logic        bus_wr;
	logic        bus_rd;

	// ****************************************
	// data memory
	// ****************************************
	file_memory u_mem (
		.clock (clock),
		.rst_b (rst_b),
		.addr  (ram_addr),
		.we    (ram_we),
		.wdata (ram_wdata),
		.rdata (ram_rdata)
	);

	// byte-lane merge of a bus write into an old value
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction : merge

	// register read view
	function automatic logic [32:0] read_reg(input state_t s, input logic [7:0] a);
		logic [32:0] r;
		r = {1'b1, 32'h0000_0000};
		unique case (a)
			CONTROL_OFFSET:   r = {1'b0, 31'h0000_0000, s.ext_en};
			ACC_OFFSET:       r = {1'b0, 24'h00_0000, s.acc};
			BANK_OFFSET:      r = {1'b0, 28'h000_0000, s.bank};
			STATUS_OFFSET:    r = {1'b0, 27'h000_0000, s.status};
			POINTER0_OFFSET:  r = {1'b0, 20'h0_0000, s.ptr[0]};
			POINTER1_OFFSET:  r = {1'b0, 20'h0_0000, s.ptr[1]};
			POINTER2_OFFSET:  r = {1'b0, 20'h0_0000, s.ptr[2]};
			MEM_ADDR_OFFSET:  r = {1'b0, 20'h0_0000, s.mem_addr};
			EXEC_INFO_OFFSET: r = {1'b0, 30'h0000_0000, s.lo_pending, s.phase != PH_IDLE};
			default:          r = {1'b1, 32'h0000_0000};
		endcase
		return r;
	endfunction : read_reg

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic [31:0] m;
		logic [32:0] rv;
		logic [7:0]  f;
		m          = 32'h0000_0000;
		rv         = 33'h0_0000_0000;
		f          = s_q.word[7:0];
		s_d        = s_q;
		ram_addr   = s_q.ea;
		ram_we     = 1'b0;
		ram_wdata  = s_q.res;
		take_instr = instr_valid && s_q.instr_ready;
		bus_wr     = s_q.aw_got && s_q.w_got && !s_q.bvalid;
		bus_rd     = s_q.ar_got && !s_q.rvalid;
		// bus channel handshakes
		if (awvalid && s_q.awready) begin
			s_d.aw_got = 1'b1;
			s_d.awaddr = awaddr;
		end
		if (wvalid && s_q.wready) begin
			s_d.w_got = 1'b1;
			s_d.wdata = wdata;
			s_d.wstrb = wstrb;
		end
		if (arvalid && s_q.arready) begin
			s_d.ar_got = 1'b1;
			s_d.araddr = araddr;
		end
		if (s_q.bvalid && bready) begin
			s_d.bvalid = 1'b0;
		end
		if (s_q.rvalid && rready) begin
			s_d.rvalid = 1'b0;
		end
		unique case (s_q.phase)
			PH_IDLE: begin
				if (take_instr) begin
					s_d.word  = instr_word;
					s_d.phase = PH_Q1;
					s_d.op    = OP_NONE;
					if (s_q.lo_pending) begin
						s_d.lo_pending = 1'b0;
						if (instr_word[15:8] == POINTER_SECOND_HI) begin
							s_d.op = OP_PTR_LO;
						end
					end else if (instr_word[15:8] == OR_LITERAL_BYTE) begin
						s_d.op = OP_OR_LIT;
					end else if (instr_word[15:10] == OR_FILE_OPCODE) begin
						s_d.op = OP_OR_FILE;
					end else if (instr_word[15:10] == MOVE_FILE_OPCODE) begin
						s_d.op = OP_MOVE_FILE;
					end else if (instr_word[15:6] == POINTER_FIRST_CODE) begin
						s_d.op = OP_PTR_HI;
					end
				end else if (bus_wr) begin
					rv           = read_reg(s_q, s_q.awaddr);
					m            = merge(rv[31:0], s_q.wdata, s_q.wstrb); // lanes merged into old value
					s_d.aw_got   = 1'b0;
					s_d.w_got    = 1'b0;
					s_d.bvalid   = 1'b1;
					s_d.bresp    = RESP_OKAY;
					unique case (s_q.awaddr)
						CONTROL_OFFSET:  s_d.ext_en   = m[0];
						ACC_OFFSET:      s_d.acc      = m[7:0];
						BANK_OFFSET:     s_d.bank     = m[3:0];
						STATUS_OFFSET:   s_d.status   = m[4:0];
						POINTER0_OFFSET: s_d.ptr[0]   = m[11:0];
						POINTER1_OFFSET: s_d.ptr[1]   = m[11:0];
						POINTER2_OFFSET: s_d.ptr[2]   = m[11:0];
						MEM_ADDR_OFFSET: s_d.mem_addr = m[11:0];
						MEM_DATA_OFFSET: begin
							ram_addr  = s_q.mem_addr;
							ram_wdata = s_q.wdata[7:0];
							ram_we    = s_q.wstrb[0];
						end
						EXEC_INFO_OFFSET: begin
							s_d.bresp = RESP_OKAY; // read-only, write ignored
						end
						default: begin
							s_d.bresp = RESP_SLVERR;
						end
					endcase
				end else if (bus_rd) begin
					if (s_q.araddr == MEM_DATA_OFFSET) begin
						ram_addr  = s_q.mem_addr;
						s_d.phase = PH_BUS_RD;
					end else begin
						rv         = read_reg(s_q, s_q.araddr);
						s_d.rdata  = rv[31:0];
						s_d.rresp  = rv[32] ? RESP_SLVERR : RESP_OKAY;
						s_d.rvalid = 1'b1;
						s_d.ar_got = 1'b0;
					end
				end
			end
			PH_BUS_RD: begin
				s_d.rdata  = {24'h00_0000, ram_rdata};
				s_d.rresp  = RESP_OKAY;
				s_d.rvalid = 1'b1;
				s_d.ar_got = 1'b0;
				s_d.phase  = PH_IDLE;
			end
			// decode: form the 12-bit effective address
			PH_Q1: begin
				if (s_q.word[BANK_BIT]) begin
					s_d.ea = {s_q.bank, f};
				end else if (s_q.ext_en && f <= INDEXED_LIMIT) begin
					s_d.ea = s_q.ptr[INDEX_POINTER] + {4'h0, f};
				end else if (f <= INDEXED_LIMIT) begin
					s_d.ea = {4'h0, f};
				end else begin
					s_d.ea = {ACCESS_HIGH_BANK, f};
				end
				s_d.phase = PH_Q2;
			end
			// operand read issued on ea
			PH_Q2: begin
				s_d.phase = PH_Q3;
			end
			// process data
			PH_Q3: begin
				unique case (s_q.op)
					OP_OR_LIT:    s_d.res = s_q.acc | f;
					OP_OR_FILE:   s_d.res = s_q.acc | ram_rdata;
					OP_MOVE_FILE: s_d.res = ram_rdata;
					default:      s_d.res = f;
				endcase
				s_d.phase = PH_Q4;
			end
			// write result and flags
			PH_Q4: begin
				s_d.phase = PH_IDLE;
				unique case (s_q.op)
					OP_OR_LIT: begin
						s_d.acc = s_q.res;
					end
					OP_OR_FILE, OP_MOVE_FILE: begin
						if (s_q.word[DEST_BIT]) begin
							ram_we = 1'b1;
						end else begin
							s_d.acc = s_q.res;
						end
					end
					OP_PTR_HI: begin
						s_d.lo_pending = 1'b1;
						s_d.ptr_sel    = s_q.word[5:4];
						if (s_q.word[5:4] <= POINTER_MAX) begin
							s_d.ptr[s_q.word[5:4]][11:8] = s_q.word[3:0];
						end
					end
					OP_PTR_LO: begin
						if (s_q.ptr_sel <= POINTER_MAX) begin
							s_d.ptr[s_q.ptr_sel][7:0] = s_q.word[7:0];
						end
					end
					default: begin
						s_d.phase = PH_IDLE;
					end
				endcase
				if (s_q.op inside {OP_OR_LIT, OP_OR_FILE, OP_MOVE_FILE}) begin
					s_d.status[NEG_BIT]  = s_q.res[7];
					s_d.status[ZERO_BIT] = (s_q.res == 8'h00);
				end
			end
			default: begin
				s_d.phase = PH_IDLE;
			end
		endcase
		// ready flags prepared for the next cycle
		s_d.awready     = !s_d.aw_got;
		s_d.wready      = !s_d.w_got;
		s_d.arready     = !s_d.ar_got;
		s_d.instr_ready = (s_d.phase == PH_IDLE) && !(s_d.aw_got && s_d.w_got && !s_d.bvalid)
		                  && !(s_d.ar_got && !s_d.rvalid);
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s_q        <= '0;
			s_q.phase  <= PH_IDLE;
			s_q.op     <= OP_NONE;
			s_q.acc    <= ACC_RESET;
			s_q.bank   <= BANK_RESET;
			s_q.status <= STATUS_RESET;
			s_q.ptr    <= {3{POINTER_RESET}};
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from the state register
	assign instr_ready = s_q.instr_ready;
	assign awready     = s_q.awready;
	assign wready      = s_q.wready;
	assign bvalid      = s_q.bvalid;
	assign bresp       = s_q.bresp;
	assign arready     = s_q.arready;
	assign rvalid      = s_q.rvalid;
	assign rresp       = s_q.rresp;
	assign rdata       = s_q.rdata;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	sequence s_four_phase;
		s_q.phase == PH_Q1 ##1 s_q.phase == PH_Q2 ##1 s_q.phase == PH_Q3 ##1 s_q.phase == PH_Q4
		##1 s_q.phase == PH_IDLE;
	endsequence

	property p_or_literal;
		(s_q.phase == PH_Q4 && s_q.op == OP_OR_LIT) |=> s_q.acc == ($past(s_q.acc) | $past(s_q.word[7:0]));
	endproperty
	a_or_literal: assert property (p_or_literal) else $error("or-literal result wrong");

	property p_decode_or_literal;
		(take_instr && !s_q.lo_pending && instr_word[15:8] == 8'h09) |=> s_q.op == OP_OR_LIT;
	endproperty
	a_decode_or_literal: assert property (p_decode_or_literal) else $error("or-literal not decoded");

	property p_or_file;
		(s_q.phase == PH_Q3 && s_q.op == OP_OR_FILE) |=> s_q.res == ($past(s_q.acc) | $past(ram_rdata));
	endproperty
	a_or_file: assert property (p_or_file) else $error("or-file result wrong");

	property p_destination;
		(s_q.phase == PH_Q4 && s_q.op inside {OP_OR_FILE, OP_MOVE_FILE})
		|-> (s_q.word[9] ? (ram_we && ram_wdata == s_q.res) : (!ram_we && s_d.acc == s_q.res));
	endproperty
	a_destination: assert property (p_destination) else $error("destination routing wrong");

	property p_bank_select;
		(s_q.phase == PH_Q1 && s_q.word[8]) |=> s_q.ea == {$past(s_q.bank), $past(s_q.word[7:0])};
	endproperty
	a_bank_select: assert property (p_bank_select) else $error("banked address wrong");

	property p_indexed;
		(s_q.phase == PH_Q1 && !s_q.word[8] && s_q.ext_en && s_q.word[7:0] <= 8'h5F)
		|=> s_q.ea == $past(s_q.ptr[2]) + {4'h0, $past(s_q.word[7:0])};
	endproperty
	a_indexed: assert property (p_indexed) else $error("indexed address wrong");

	property p_flags;
		(s_q.phase == PH_Q4 && s_q.op inside {OP_OR_LIT, OP_OR_FILE, OP_MOVE_FILE})
		|=> s_q.status[2] == ($past(s_q.res) == 8'h00) && s_q.status[4] == $past(s_q.res[7])
		&& {s_q.status[3], s_q.status[1:0]} == $past({s_q.status[3], s_q.status[1:0]});
	endproperty
	a_flags: assert property (p_flags) else $error("status flags wrong");

	property p_pointer_high;
		(s_q.phase == PH_Q4 && s_q.op == OP_PTR_HI && s_q.word[5:4] == 2'h1)
		|=> s_q.ptr[1][11:8] == $past(s_q.word[3:0]) && s_q.status == $past(s_q.status) && s_q.lo_pending;
	endproperty
	a_pointer_high: assert property (p_pointer_high) else $error("pointer high nibble wrong");

	property p_pointer_low;
		(s_q.phase == PH_Q4 && s_q.op == OP_PTR_LO && s_q.ptr_sel == 2'h2)
		|=> s_q.ptr[2][7:0] == $past(s_q.word[7:0]) && s_q.status == $past(s_q.status);
	endproperty
	a_pointer_low: assert property (p_pointer_low) else $error("pointer low byte wrong");

	property p_one_cycle;
		(take_instr && !s_q.lo_pending && instr_word[15:8] == 8'h09) |=> s_four_phase;
	endproperty
	a_one_cycle: assert property (p_one_cycle) else $error("instruction cycle not four phases");

endmodule : or_move_pointer_load_exec

// *** testbench/instr_source.sv ***
// instruction source standing in for the fetch and decode stage
`timescale 1ns/100ps
module instr_source (
	// clock
	input  wire logic        clock,
	// instruction handshake
	output logic             instr_valid,
	output logic [15:0]      instr_word,
	input  wire logic        instr_ready
);

	// ****************************************
	// idle levels
	// ****************************************
	initial begin
		instr_valid = 1'b0;
		instr_word  = 16'hFFFF;
	end

	// ****************************************
	// offer one word, wait until it has run
	// ****************************************
	// a word that is no longer offered shows its inverse, not a stale copy
	task automatic send(input logic [15:0] w, input int gap);
		int n;
		repeat (gap) @(posedge clock);
		instr_valid <= 1'b1;
		instr_word  <= w;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (!instr_ready && n < 1000);
		instr_valid <= 1'b0;
		instr_word  <= ~w;
		repeat (2) @(posedge clock);
		n = 0;
		while (!instr_ready && n < 1000) begin
			@(posedge clock);
			n++;
		end
	endtask : send

endmodule : instr_source

// *** testbench/or_move_pointer_load_exec_tb.sv ***
// self-checking bench for the or/move/pointer-load execution datapath
`timescale 1ns/100ps
module or_move_pointer_load_exec_tb
	import or_move_pkg::*;
;
	logic        clock;
	logic        rst_b;
	logic        instr_valid;
	logic        instr_ready;
	logic [15:0] instr_word;
	logic [7:0]  awaddr;
	logic [7:0]  araddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic [1:0]  last_bresp;
	int          miscompares;
	int          compares;

	// ****************************************
	// instances
	// ****************************************
	or_move_pointer_load_exec u_dut (.clock(clock), .rst_b(rst_b), .instr_valid(instr_valid),
		.instr_word(instr_word), .instr_ready(instr_ready), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	instr_source u_src (.clock(clock), .instr_valid(instr_valid), .instr_word(instr_word),
		.instr_ready(instr_ready));

	// clock source
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_open;
		logic w_open;
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		aw_open = 1'b1;
		w_open  = 1'b1;
		forever begin
			@(posedge clock);
			if (aw_open && awready) begin
				aw_open = 1'b0;
				awvalid <= 1'b0;
			end
			if (w_open && wready) begin
				w_open = 1'b0;
				wvalid <= 1'b0;
			end
			if (bvalid) begin
				last_bresp = bresp;
				break;
			end
		end
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar_open;
		araddr  <= a;
		arvalid <= 1'b1;
		ar_open = 1'b1;
		forever begin
			@(posedge clock);
			if (ar_open && arready) begin
				ar_open = 1'b0;
				arvalid <= 1'b0;
			end
			if (rvalid) begin
				d = rdata;
				r = rresp;
				break;
			end
		end
	endtask : rd

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		check(d, exp);
		check({30'h0, r}, {30'h0, RESP_OKAY});
	endtask : rd_chk

	task automatic set_mem(input logic [11:0] a, input logic [7:0] d);
		wr(MEM_ADDR_OFFSET, {20'h0, a});
		wr(MEM_DATA_OFFSET, {24'h0, d});
	endtask : set_mem

	task automatic mem_chk(input logic [11:0] a, input logic [7:0] exp);
		wr(MEM_ADDR_OFFSET, {20'h0, a});
		rd_chk(MEM_DATA_OFFSET, {24'h0, exp});
	endtask : mem_chk

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0]  r;
		rd_chk(ACC_OFFSET, {24'h0, ACC_RESET});
		rd_chk(STATUS_OFFSET, {27'h0, STATUS_RESET});
		rd_chk(POINTER2_OFFSET, {20'h0, POINTER_RESET});
		rd_chk(EXEC_INFO_OFFSET, 32'h0);
		rd(8'h30, d, r);
		check(d, 32'h0);
		check({30'h0, r}, {30'h0, RESP_SLVERR});
		wr(8'h30, 32'h1);
		check({30'h0, last_bresp}, {30'h0, RESP_SLVERR});
		wr(EXEC_INFO_OFFSET, 32'h3);
		check({30'h0, last_bresp}, {30'h0, RESP_OKAY});
		rd_chk(EXEC_INFO_OFFSET, 32'h0);
	endtask : t_reset

	// each pointer gets its literal; field three loads nothing
	task automatic t_pointer;
		logic [11:0] ks [3];
		logic [7:0]  pa;
		ks = '{12'hFFF, 12'h3AB, 12'h001};
		wr(STATUS_OFFSET, 32'h15);
		for (int f = 0; f < 3; f++) begin
			pa = POINTER0_OFFSET + 8'(4 * f);
			u_src.send({8'hEE, 2'b00, 2'(f), ks[f][11:8]}, 0);
			rd_chk(EXEC_INFO_OFFSET, 32'h2);
			rd_chk(pa, {20'h0, ks[f][11:8], 8'h00});
			u_src.send({POINTER_SECOND_HI, ks[f][7:0]}, 3);
			rd_chk(pa, {20'h0, ks[f]});
		end
		u_src.send(16'hEE35, 0);
		u_src.send(16'hF077, 0);
		rd_chk(POINTER0_OFFSET, 32'hFFF);
		rd_chk(STATUS_OFFSET, 32'h15);
	endtask : t_pointer

	task automatic t_or_literal;
		wr(ACC_OFFSET, 32'h9A);
		wr(STATUS_OFFSET, 32'h0B);
		u_src.send(16'h0935, 0);
		rd_chk(ACC_OFFSET, 32'hBF);
		rd_chk(STATUS_OFFSET, 32'h1B);
		u_src.send(16'h0E55, 0);
		rd_chk(ACC_OFFSET, 32'hBF);
		wr(ACC_OFFSET, 32'h00);
		u_src.send(16'h0900, 0);
		rd_chk(STATUS_OFFSET, 32'h0F);
	endtask : t_or_literal

	task automatic t_file;
		wr(BANK_OFFSET, 32'h3);
		set_mem(12'h321, 8'h13);
		wr(ACC_OFFSET, 32'h91);
		u_src.send(16'h1121, 0);
		rd_chk(ACC_OFFSET, 32'h93);
		mem_chk(12'h321, 8'h13);
		set_mem(12'h022, 8'h22);
		u_src.send(16'h5022, 0);
		rd_chk(ACC_OFFSET, 32'h22);
		set_mem(12'hF80, 8'h00);
		wr(STATUS_OFFSET, 32'h10);
		u_src.send(16'h5280, 0);
		rd_chk(STATUS_OFFSET, 32'h04);
		rd_chk(ACC_OFFSET, 32'h22);
		set_mem(12'h3FF, 8'h40);
		u_src.send(16'h13FF, 0);
		mem_chk(12'h3FF, 8'h62);
	endtask : t_file

	task automatic t_indexed;
		wr(CONTROL_OFFSET, 32'h1);
		wr(POINTER2_OFFSET, 32'h200);
		set_mem(12'h25F, 8'h40);
		wr(ACC_OFFSET, 32'h05);
		u_src.send(16'h125F, 0);
		mem_chk(12'h25F, 8'h45);
		set_mem(12'hF60, 8'h80);
		u_src.send(16'h1060, 0);
		rd_chk(ACC_OFFSET, 32'h85);
		wr(CONTROL_OFFSET, 32'h0);
	endtask : t_indexed

	// ****************************************
	// verdict
	// ****************************************
	task automatic final_report;
		if (miscompares == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : final_report

	// main sequence
	initial begin
		miscompares = 0;
		compares    = 0;
		rst_b   = 1'b0;
		awaddr  = 8'h00;
		araddr  = 8'h00;
		awvalid = 1'b0;
		wvalid  = 1'b0;
		arvalid = 1'b0;
		wdata   = 32'h0;
		wstrb   = 4'hF;
		bready  = 1'b1;
		rready  = 1'b1;
		repeat (4) @(posedge clock);
		rst_b <= 1'b1;
		repeat (2) @(posedge clock);
		t_reset();
		t_pointer();
		t_or_literal();
		t_file();
		t_indexed();
		final_report();
	end

	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge clock);
		miscompares++;
		final_report();
	end

endmodule : or_move_pointer_load_exec_tb
